// ### src/tdmlc_top.sv
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module tdmlc_top (
  // System side
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clkEn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link timing
  input wire logic masterTdmClockIn,
  input wire logic masterFramePulseIn,
  input wire logic outputDriveEnable,
  // Input lanes
  input wire logic [23:0] inputLaneA,
  input wire logic [23:0] inputLaneB,
  input wire logic [23:0] inputLaneC,
  input wire logic [23:0] inputLaneD,
  // Output lanes with enables
  output logic [23:0] outputLaneA,
  output logic [23:0] outputLaneB,
  output logic [23:0] outputLaneC,
  output logic [23:0] outputLaneD,
  output logic [23:0] outputLaneAOe,
  output logic [23:0] outputLaneBOe,
  output logic [23:0] outputLaneCOe,
  output logic [23:0] outputLaneDOe,
  // Core side, link clock domain
  output logic [95:0] rxData,
  output logic [23:0] rxGroupStrobe,
  input wire logic [95:0] txData,
  output logic [23:0] txGroupStrobe
);

  // ****************************************************************
  // APB register file (mclk)
  // ****************************************************************
  logic [5:0] cfg [tdmlc_pkg::GROUPS];
  logic [5:0] shadow [tdmlc_pkg::GROUPS];
  logic cfgPend;
  logic reqTgl;
  logic ackS1;
  logic ackS2;
  logic frS1;
  logic frS2;
  logic frS3;
  logic [15:0] frameCount;
  logic apbAcc;
  logic [5:0] wIdx;
  logic grpHit;
  logic statHit;
  logic cfgWrite;
  logic cfgCopy;
  // Toggles raised in the link domain, read here only through two flops
  logic ackTgl;
  logic frameTgl;

  // Decode
  assign apbAcc = psel & penable;
  assign wIdx = paddr[7:2];
  assign grpHit = (paddr[1:0] == 2'h0) && (wIdx < 6'(tdmlc_pkg::GROUPS));
  assign statHit = (paddr == tdmlc_pkg::ADDR_STATUS);
  assign cfgWrite = clkEn & apbAcc & pready & pwrite & grpHit;
  // Config only moves when the previous handshake is closed
  assign cfgCopy = clkEn & cfgPend & (reqTgl == ackS2);

  // Answer one cycle into the access phase; unmapped gives slverr
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else if (clkEn)
    begin
      if (apbAcc && !pready)
      begin
        pready <= 1'b1;
        pslverr <= !(grpHit || statHit);
        if (grpHit)
          prdata <= {26'h0, cfg[wIdx[4:0]]};
        else if (statHit)
          prdata <= {15'h0, cfgPend, frameCount};
        else
          prdata <= 32'h0;
      end
      else
      begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // Group control words
  // separate rate codes
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int g = 0; g < tdmlc_pkg::GROUPS; g++)
        cfg[g] <= tdmlc_pkg::CFG_RESET;
    end
    else if (cfgWrite)
      cfg[wIdx[4:0]] <= pwdata[5:0];
  end

  // Pending flag: a write in the copy cycle keeps it set
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      cfgPend <= 1'b0;
    else if (cfgWrite)
      cfgPend <= 1'b1;
    else if (cfgCopy)
      cfgPend <= 1'b0;
  end

  // Shadow is held still while the link side copies it
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      reqTgl <= 1'b0;
      for (int g = 0; g < tdmlc_pkg::GROUPS; g++)
        shadow[g] <= tdmlc_pkg::CFG_RESET;
    end
    else if (cfgCopy)
    begin
      reqTgl <= ~reqTgl;
      shadow <= cfg;
    end
  end

  // Return crossings: acknowledge and frame toggle
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ackS1 <= 1'b0;
      ackS2 <= 1'b0;
      frS1 <= 1'b0;
      frS2 <= 1'b0;
      frS3 <= 1'b0;
      frameCount <= 16'h0;
    end
    else if (clkEn)
    begin
      ackS1 <= ackTgl;
      ackS2 <= ackS1;
      frS1 <= frameTgl;
      frS2 <= frS1;
      frS3 <= frS2;
      if (frS2 != frS3)
        frameCount <= frameCount + 16'h1;
    end
  end

  // ****************************************************************
  // Link domain (masterTdmClockIn)
  // ****************************************************************
  logic lrS1;
  logic lrstn;
  logic ceS1;
  logic lce;
  logic reqS1;
  logic reqS2;
  logic reqS3;
  logic [5:0] lcfg [tdmlc_pkg::GROUPS];
  logic fpS1;
  logic fpS2;
  logic fpS3;
  logic [2:0] phase;
  logic [2:0] next_phase;
  logic [95:0] inS1;
  logic [95:0] inS2;
  logic [23:0] inTick;
  logic [95:0] oData;
  logic [95:0] oe;
  logic oeClrN;

  // Reset release aligned to the link clock
  always_ff @(posedge masterTdmClockIn or negedge rstn)
  begin
    if (!rstn)
    begin
      lrS1 <= 1'b0;
      lrstn <= 1'b0;
    end
    else
    begin
      lrS1 <= 1'b1;
      lrstn <= lrS1;
    end
  end

  // Clock enable brought across; these two flops never freeze
  always_ff @(posedge masterTdmClockIn or negedge lrstn)
  begin
    if (!lrstn)
    begin
      ceS1 <= 1'b0;
      lce <= 1'b0;
    end
    else
    begin
      ceS1 <= clkEn;
      lce <= ceS1;
    end
  end

  // Config handshake receiver
  always_ff @(posedge masterTdmClockIn or negedge lrstn)
  begin
    if (!lrstn)
    begin
      reqS1 <= 1'b0;
      reqS2 <= 1'b0;
      reqS3 <= 1'b0;
      ackTgl <= 1'b0;
      for (int g = 0; g < tdmlc_pkg::GROUPS; g++)
        lcfg[g] <= tdmlc_pkg::CFG_RESET;
    end
    else if (lce)
    begin
      reqS1 <= reqTgl;
      reqS2 <= reqS1;
      reqS3 <= reqS2;
      if (reqS2 != reqS3)
      begin
        lcfg <= shadow;
        ackTgl <= reqS2;
      end
    end
  end

  // Frame pulse sync and bit phase; frame start restarts the phase
  assign next_phase = (fpS2 && !fpS3) ? 3'h0 : phase + 3'h1;
  always_ff @(posedge masterTdmClockIn or negedge lrstn)
  begin
    if (!lrstn)
    begin
      fpS1 <= 1'b0;
      fpS2 <= 1'b0;
      fpS3 <= 1'b0;
      frameTgl <= 1'b0;
      phase <= 3'h0;
    end
    else if (lce)
    begin
      fpS1 <= masterFramePulseIn;
      fpS2 <= fpS1;
      fpS3 <= fpS2;
      phase <= next_phase;
      if (fpS2 && !fpS3)
        frameTgl <= ~frameTgl;
    end
  end

  // Bit ticks: high in the cycle whose closing edge moves a bit
  // per-group rate timing
  always_ff @(posedge masterTdmClockIn or negedge lrstn)
  begin
    if (!lrstn)
    begin
      inTick <= 24'h0;
      txGroupStrobe <= 24'h0;
    end
    else if (lce)
    begin
      for (int g = 0; g < tdmlc_pkg::GROUPS; g++)
      begin
        inTick[g] <= (next_phase & tdmlc_pkg::stepMask(lcfg[g][1:0])) == 3'h0;
        txGroupStrobe[g] <= (next_phase & tdmlc_pkg::stepMask(lcfg[g][3:2])) == 3'h0;
      end
    end
  end

  // Input pins pass two flops before use
  always_ff @(posedge masterTdmClockIn or negedge lrstn)
  begin
    if (!lrstn)
    begin
      inS1 <= 96'h0;
      inS2 <= 96'h0;
    end
    else if (lce)
    begin
      inS1 <= {inputLaneD, inputLaneC, inputLaneB, inputLaneA};
      inS2 <= inS1;
    end
  end

  // Receive capture; lane l of group g sits at bit l*24+g
  // lane use by rate
  always_ff @(posedge masterTdmClockIn or negedge lrstn)
  begin
    if (!lrstn)
    begin
      rxData <= 96'h0;
      rxGroupStrobe <= 24'h0;
    end
    else if (lce)
    begin
      rxGroupStrobe <= inTick;
      for (int l = 0; l < tdmlc_pkg::LANES; l++)
        for (int g = 0; g < tdmlc_pkg::GROUPS; g++)
          if (inTick[g])
          begin
            rxData[l*24+g] <= tdmlc_pkg::laneUsed(lcfg[g][1:0], l) &
                              (inS2[l*24+g] ^ lcfg[g][tdmlc_pkg::CFG_IN_INV]);
          end
    end
  end

  // Transmit data; unused lanes park low behind their off enable
  always_ff @(posedge masterTdmClockIn or negedge lrstn)
  begin
    if (!lrstn)
      oData <= 96'h0;
    else if (lce)
    begin
      for (int l = 0; l < tdmlc_pkg::LANES; l++)
        for (int g = 0; g < tdmlc_pkg::GROUPS; g++)
          if (txGroupStrobe[g])
          begin
            oData[l*24+g] <= tdmlc_pkg::laneUsed(lcfg[g][3:2], l) &
                             (txData[l*24+g] ^ lcfg[g][tdmlc_pkg::CFG_OUT_INV]);
          end
    end
  end

  // Drive enables; drive enable pin clears them without a clock
  // asynchronous tristate
  assign oeClrN = lrstn & outputDriveEnable;
  always_ff @(posedge masterTdmClockIn or negedge oeClrN)
  begin
    if (!oeClrN)
      oe <= 96'h0;
    else if (lce)
    begin
      for (int l = 0; l < tdmlc_pkg::LANES; l++)
        for (int g = 0; g < tdmlc_pkg::GROUPS; g++)
          if (txGroupStrobe[g])
          begin
            oe[l*24+g] <= tdmlc_pkg::laneUsed(lcfg[g][3:2], l);
          end
    end
  end

  // Pin slices straight from the flops
  assign outputLaneA = oData[23:0];
  assign outputLaneB = oData[47:24];
  assign outputLaneC = oData[71:48];
  assign outputLaneD = oData[95:72];
  assign outputLaneAOe = oe[23:0];
  assign outputLaneBOe = oe[47:24];
  assign outputLaneCOe = oe[71:48];
  assign outputLaneDOe = oe[95:72];

  // ****************************************************************
  // Assertions, group 0 as representative
  // ****************************************************************
  logic [1:0] r0In;
  logic [1:0] r0Out;
  assign r0In = lcfg[0][1:0];
  assign r0Out = lcfg[0][3:2];

  a_lane_a_rx: assert property (@(posedge masterTdmClockIn) disable iff (!lrstn)
    lce && inTick[0] |=> rxData[0] == ($past(inS2[0]) ^ $past(lcfg[0][4])))
    else $error("lane A capture wrong");
  a_lane_b_mute: assert property (@(posedge masterTdmClockIn) disable iff (!lrstn)
    lce && inTick[0] && r0In == 2'h3 |=> !rxData[24])
    else $error("lane B not ignored at top rate");
  a_lane_c_mute: assert property (@(posedge masterTdmClockIn) disable iff (!lrstn)
    lce && inTick[0] && r0In[1] |=> !rxData[48])
    else $error("lane C not ignored");
  a_lane_d_mute: assert property (@(posedge masterTdmClockIn) disable iff (!lrstn)
    lce && inTick[0] && r0In[1] |=> !rxData[72])
    else $error("lane D not ignored");
  a_out_a_drive: assert property (@(posedge masterTdmClockIn) disable iff (!lrstn)
    lce && txGroupStrobe[0] && outputDriveEnable ##1 outputDriveEnable |-> oe[0])
    else $error("lane A not driven");
  a_out_b_hiz: assert property (@(posedge masterTdmClockIn) disable iff (!lrstn)
    lce && txGroupStrobe[0] && r0Out == 2'h3 |=> !oe[24] && !oData[24])
    else $error("lane B driven at top rate");
  a_out_c_hiz: assert property (@(posedge masterTdmClockIn) disable iff (!lrstn)
    lce && txGroupStrobe[0] && r0Out[1] |=> !oe[48])
    else $error("lane C driven at high rate");
  a_out_d_hiz: assert property (@(posedge masterTdmClockIn) disable iff (!lrstn)
    lce && txGroupStrobe[0] && r0Out[1] |=> !oe[72])
    else $error("lane D driven at high rate");
  a_out_polarity: assert property (@(posedge masterTdmClockIn) disable iff (!lrstn)
    lce && txGroupStrobe[0] |=> oData[0] == ($past(txData[0]) ^ $past(lcfg[0][5])))
    else $error("output polarity wrong");
  a_ode_hiz: assert property (@(posedge masterTdmClockIn) disable iff (!lrstn)
    !outputDriveEnable |-> oe == 96'h0)
    else $error("lane driven with drive enable low");
  a_cfg_handoff: assert property (@(posedge mclk) disable iff (!rstn)
    cfgCopy |=> shadow[0] == $past(cfg[0]) ##[1:40] ackS2 == reqTgl)
    else $error("config handshake stuck");
  a_apb_answer: assert property (@(posedge mclk) disable iff (!rstn)
    clkEn && apbAcc && !pready |=> pready ##1 !pready)
    else $error("APB answer timing wrong");

  c_rate_top: cover property (@(posedge masterTdmClockIn) r0In == 2'h3 && inTick[0]);
  c_rate_low: cover property (@(posedge masterTdmClockIn) r0Out == 2'h0 && oe[72]);
  c_ode_low: cover property (@(posedge masterTdmClockIn) !outputDriveEnable ##1 outputDriveEnable);
  c_cfg_write: cover property (@(posedge mclk) cfgWrite ##[1:40] !cfgPend);

endmodule
`default_nettype wire

// ### src/tdmlc_pkg.sv
package tdmlc_pkg;

  // ****************************************************************
  // Stream organisation
  // ****************************************************************
  localparam int GROUPS = 24;
  localparam int LANES = 4;
  localparam int LANE_BITS = 96;
  localparam int LANE_A = 0;
  localparam int LANE_B = 1;
  localparam int LANE_C = 2;
  localparam int LANE_D = 3;

  // ****************************************************************
  // Register map, byte addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_GROUP0 = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h60;
  localparam int CFG_W = 6;
  localparam int CFG_IN_RATE = 0;
  localparam int CFG_OUT_RATE = 2;
  localparam int CFG_IN_INV = 4;
  localparam int CFG_OUT_INV = 5;
  localparam logic [5:0] CFG_RESET = 6'h00;
  localparam int STAT_FRAMES = 0;
  localparam int STAT_PEND = 16;

  // Group rate codes: 8.192, 16.384, 32.768, 65.536 Mbps
  typedef enum logic [1:0] {
    RATE_8M = 2'b00,
    RATE_16M = 2'b01,
    RATE_32M = 2'b10,
    RATE_65M = 2'b11
  } tdmlc_rate_t;

  // Which lanes carry data at a given group rate
  function automatic logic laneUsed(input logic [1:0] rate, input int lane);
    logic used;
    used = (lane == LANE_A) || (lane == LANE_B && rate != RATE_65M) ||
           (rate == RATE_8M) || (rate == RATE_16M);
    return used;
  endfunction

  // Phase bits that must be zero on a bit boundary (link clock at 65.536)
  function automatic logic [2:0] stepMask(input logic [1:0] rate);
    logic [2:0] m;
    case (rate)
      RATE_65M: m = 3'h0;
      RATE_32M: m = 3'h1;
      RATE_16M: m = 3'h3;
      default: m = 3'h7;
    endcase
    return m;
  endfunction

endpackage

// ### testbench/tdmlc_far_end.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Far-end framer model
// ****
module tdmlc_far_end (
  // Link timing
  input wire logic linkClk,
  output logic framePulse,
  // Input lane levels, bit l*24+g
  input wire logic [95:0] laneDrive,
  output logic [95:0] inLanes,
  // Output lanes as seen on the wire
  input wire logic [95:0] outData,
  input wire logic [95:0] outOe,
  output logic [95:0] lineLvl
);
  logic [5:0] frameCnt = 6'h00;
  logic toggle = 1'b0;
  // Frame pulse once in 64 link clocks, one clock wide
  always @(posedge linkClk)
  begin
    frameCnt <= frameCnt + 6'h01;
    framePulse <= (frameCnt == 6'h3F);
    toggle <= ~toggle;
  end
  // input lane levels follow laneDrive, registered on the link clock
  always @(posedge linkClk)
    inLanes <= laneDrive;
  // Released lines wander, so a stale value never looks driven
  assign lineLvl = (outOe & outData) | (~outOe & {96{toggle}});
endmodule
`default_nettype wire

// ### testbench/tdm_stream_group_lane_config_test.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Lane rate and polarity bench
// ****
module tdm_stream_group_lane_config_test;
  logic mclk = 1'b0;
  logic linkClk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic output_drive_enable = 1'b1;
  logic [95:0] laneDrive = {4{24'h000001}};
  logic [95:0] txData = {4{24'h800001}};
  logic [95:0] ed;
  logic [95:0] eo;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire framePulse;
  wire [95:0] inLanes;
  wire [95:0] outData;
  wire [95:0] outOe;
  wire [95:0] lineLvl;
  wire [95:0] rxData;
  wire [23:0] rxGroupStrobe;
  wire [23:0] txGroupStrobe;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;

  // Free-running clocks, link offset so edges never meet
  always #50 mclk = ~mclk;
  initial
  begin
    #7;
    forever #15 linkClk = ~linkClk;
  end

  tdmlc_top u_dut (.mclk(mclk), .rstn(rstn), .clkEn(1'b1), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .masterTdmClockIn(linkClk), .masterFramePulseIn(framePulse),
    .outputDriveEnable(output_drive_enable), .inputLaneA(inLanes[23:0]), .inputLaneB(inLanes[47:24]),
    .inputLaneC(inLanes[71:48]), .inputLaneD(inLanes[95:72]), .outputLaneA(outData[23:0]),
    .outputLaneB(outData[47:24]), .outputLaneC(outData[71:48]), .outputLaneD(outData[95:72]),
    .outputLaneAOe(outOe[23:0]), .outputLaneBOe(outOe[47:24]), .outputLaneCOe(outOe[71:48]),
    .outputLaneDOe(outOe[95:72]), .rxData(rxData), .rxGroupStrobe(rxGroupStrobe),
    .txData(txData), .txGroupStrobe(txGroupStrobe));

  tdmlc_far_end u_far (.linkClk(linkClk), .framePulse(framePulse), .laneDrive(laneDrive),
    .inLanes(inLanes), .outData(outData), .outOe(outOe), .lineLvl(lineLvl));

  task automatic print_verdict();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] eq, input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk({63'h0, e, q}, {63'h0, ee, eq}, "register read");
  endtask

  // Pending flag clears at the shadow copy; config is live in the link domain a few link clocks later
  task automatic settle(input logic tx);
    logic [31:0] q;
    logic e;
    q = 32'h00010000;
    while (q[16] !== 1'b0)
      apb(1'b0, tdmlc_pkg::ADDR_STATUS, 32'h0, q, e);
    repeat (3)
    begin
      @(posedge linkClk);
      while ((tx ? txGroupStrobe[0] : rxGroupStrobe[0]) !== 1'b1)
        @(posedge linkClk);
    end
    @(negedge linkClk);
  endtask

  function automatic logic used(input int l, input int r);
    return l == 0 || (l == 1 && r != 3) || r < 2;
  endfunction

  // Reset values, field widths, refused addresses
  task automatic reg_access();
    rdchk(8'h00, {26'h0, tdmlc_pkg::CFG_RESET}, 1'b0);
    wr(8'h14, 32'hFFFFFFFF);
    rdchk(8'h14, 32'h0000003F, 1'b0);
    wr(8'h14, 32'h00000009);
    rdchk(8'h14, 32'h00000009, 1'b0);
    rdchk(8'h64, 32'h0, 1'b1);
    rdchk(8'h02, 32'h0, 1'b1);
    wr(8'h14, 32'h0);
  endtask

  // Every rate on groups 0 and 23; group 23 inverted, pins low elsewhere
  task automatic rate_sweep();
    for (int r = 0; r < 4; r++)
    begin
      wr(8'h00, 32'(r * 5));
      wr(8'h5C, 32'(r * 5 + 48));
      ed = '0;
      eo = '1;
      for (int l = 0; l < 4; l++)
      begin
        ed[l * 24] = used(l, r);
        ed[l * 24 + 23] = used(l, r);
      end
      settle(1'b0);
      chk(rxData, ed, "received lanes");
      for (int l = 0; l < 4; l++)
      begin
        eo[l * 24] = used(l, r);
        eo[l * 24 + 23] = used(l, r);
        ed[l * 24 + 23] = 1'b0;
      end
      settle(1'b1);
      chk(outOe, eo, "output enables");
      chk(lineLvl & eo, ed, "output levels");
    end
  endtask

  // Drive enable low releases every lane at once
  task automatic drive_enable();
    @(posedge mclk);
    output_drive_enable <= 1'b0;
    @(negedge mclk);
    chk(outOe, 96'h0, "drive enable off");
    @(posedge mclk);
    output_drive_enable <= 1'b1;
    settle(1'b1);
    chk(outOe, eo, "drive enable back");
  endtask

  // Frame starts seen over about 205 link clocks: three or four frames of 64
  task automatic frame_count();
    logic [31:0] q0;
    logic [31:0] q1;
    logic [15:0] diff;
    logic e;
    apb(1'b0, tdmlc_pkg::ADDR_STATUS, 32'h0, q0, e);
    repeat (192) @(posedge linkClk);
    apb(1'b0, tdmlc_pkg::ADDR_STATUS, 32'h0, q1, e);
    diff = q1[15:0] - q0[15:0];
    checks++;
    if (diff < 16'h0003 || diff > 16'h0004)
    begin
      error_cnt++;
      $display("unexpected %0t frame count step %0d", $time, diff);
    end
  endtask

  initial
  begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    reg_access();
    rate_sweep();
    drive_enable();
    frame_count();
    print_verdict();
  end
endmodule
`default_nettype wire
